// ---- fmm_regs.vh ----
// Constants for the float multiply-accumulate / maximum datapath
`ifndef FMM_REGS_VH
`define FMM_REGS_VH
// Opcode first-word patterns and masks, plus the register-maximum second-word mask
`define FMM_MAC_PAT      16'hE3C0
`define FMM_MAC_MASK     16'hFFF0
`define FMM_MAXR_PAT     16'hE696
`define FMM_MAXR_MASK    16'hFFFF
`define FMM_MAXR_W2MASK  16'hFFC0
`define FMM_MAXI_PAT     16'hE820
`define FMM_MAXI_MASK    16'hFFF8
// Status flag bit positions
`define FMM_BIT_OVF_LATCH 0
`define FMM_BIT_UNF_LATCH 1
`define FMM_BIT_FNEG      2
`define FMM_BIT_FZERO     3
`define FMM_BIT_INEG      4
`define FMM_BIT_IZERO     5
`define FMM_BIT_TEST      6
// Special values
`define FMM_POS_INF      32'h7F800000
`define FMM_POS_ZERO     32'h00000000
// Latency and status reset value
`define FMM_MAC_LAT      2
`define FMM_STAT_RST     7'h00
`endif

// ---- fmm_fp_unit.v ----
// Single-precision multiply or add with flush, clamp and range flags
`timescale 1ns/1ps
`default_nettype none
`include "fmm_regs.vh"
module fmm_fp_unit (
  input  wire [31:0] op_a,
  input  wire [31:0] op_b,
  input  wire        is_mul,
  output reg  [31:0] res,
  output reg         uflow,
  output reg         oflow
);
  reg        sa, sb, sr;
  reg [7:0]  ea, eb;
  reg [23:0] ma, mb;
  reg [47:0] prod;
  reg [9:0]  ex;
  reg [24:0] sum;
  reg [23:0] mbs;
  reg [7:0]  dif;
  reg [4:0]  lz;
  integer    i;
  integer    lzi;
  reg        found;
  always @* begin
    sa = op_a[31];
    sb = op_b[31];
    ea = op_a[30:23];
    eb = op_b[30:23];
    // Denormal inputs flushed to zero
    ma = (ea == 8'h00) ? 24'h000000 : {1'b1, op_a[22:0]};
    mb = (eb == 8'h00) ? 24'h000000 : {1'b1, op_b[22:0]};
    prod = 48'h0;
    sum = 25'h0;
    mbs = 24'h0;
    dif = 8'h0;
    lz = 5'd0;
    lzi = 0;
    found = 1'b0;
    sr = sa;
    ex = 10'd0;
    res = `FMM_POS_ZERO;
    uflow = 1'b0;
    oflow = 1'b0;
    if (is_mul) begin
      sr = sa ^ sb;
      prod = ma * mb;
      ex = {2'b00, ea} + {2'b00, eb} - 10'd127;
      if (prod[47]) begin
        ex = ex + 10'd1;
        prod = prod >> 1;
      end
      if (ma == 24'h0 || mb == 24'h0) begin
        res = {sr, 31'h0};
      end else if (ex[9] || ex == 10'd0) begin
        uflow = 1'b1;
        res = {sr, 31'h0};
      end else if (ex >= 10'd255) begin
        oflow = 1'b1;
        res = {sr, 8'hFF, 23'h0};
      end else begin
        res = {sr, ex[7:0], prod[45:23]};
      end
    end else begin
      // Order so that a has the larger magnitude
      if ({ea, ma} < {eb, mb}) begin
        {sa, sb} = {sb, sa};
        {ea, eb} = {eb, ea};
        {ma, mb} = {mb, ma};
      end
      sr = sa;
      dif = ea - eb;
      mbs = (dif > 8'd23) ? 24'h0 : (mb >> dif);
      sum = (sa == sb) ? ({1'b0, ma} + {1'b0, mbs}) : ({1'b0, ma} - {1'b0, mbs});
      ex = {2'b00, ea};
      if (sum[24]) begin
        sum = sum >> 1;
        ex = ex + 10'd1;
      end else begin
        // Leading-one search from the top; only the first hit counts
        for (i = 23; i >= 0; i = i - 1) begin
          if (sum[i] && !found) begin
            found = 1'b1;
            lzi = 23 - i;
            lz = lzi[4:0];
          end
        end
        sum = sum << lz;
        ex = ex - {5'd0, lz};
      end
      if (sum == 25'h0) begin
        res = `FMM_POS_ZERO;
      end else if (ex[9] || ex == 10'd0) begin
        uflow = 1'b1;
        res = {sr, 31'h0};
      end else if (ex >= 10'd255) begin
        oflow = 1'b1;
        res = {sr, 8'hFF, 23'h0};
      end else begin
        res = {sr, ex[7:0], sum[22:0]};
      end
    end
  end
endmodule
`default_nettype wire

// ---- fmm_datapath.v ----
// Float multiply-accumulate with parallel move, and float maximum
`timescale 1ns/1ps
`default_nettype none
`include "fmm_regs.vh"
module fmm_datapath #(
  parameter NREG = 8
) (
  input  wire        clk_sys,
  input  wire        reset,
  input  wire        issue_valid,
  input  wire [15:0] instr_word1,
  input  wire [15:0] instr_word2,
  input  wire [31:0] mem_rdata,
  input  wire        reg_wr_en,
  input  wire [2:0]  reg_wr_sel,
  input  wire [31:0] reg_wr_data,
  input  wire [2:0]  reg_rd_sel,
  output reg  [31:0] reg_rd_data_q,
  output reg  [6:0]  float_status_register_q,
  output reg         op_accepted_q,
  output reg         mac_busy_q
);
  // ****************************************
  // Register file and decode
  // ****************************************
  reg  [31:0] fr_q [0:NREG-1];
  reg  [31:0] fr_d [0:NREG-1];
  reg  [6:0]  stat_d;
  wire is_mac  = issue_valid && ((instr_word1 & `FMM_MAC_MASK) == `FMM_MAC_PAT);
  wire is_maxr = issue_valid && (instr_word1 == `FMM_MAXR_PAT)
                 && ((instr_word2 & `FMM_MAXR_W2MASK) == 16'h0000);
  wire is_maxi = issue_valid && ((instr_word1 & `FMM_MAXI_MASK) == `FMM_MAXI_PAT);
  // Multiply-accumulate fields: fffe in word 1, eedd daaa in word 2
  wire [2:0] mac_f   = instr_word1[3:1];
  wire [2:0] mac_e   = {instr_word1[0], instr_word2[15:14]};
  wire [2:0] mac_d   = instr_word2[13:11];
  wire [2:0] mac_a   = instr_word2[10:8];
  wire [2:0] max_a   = instr_word2[2:0];
  wire [2:0] max_b   = instr_word2[5:3];
  wire [31:0] imm_val = {instr_word1[2:0], instr_word2[15:3], 16'h0000};

  // ****************************************
  // Functions
  // ****************************************
  // Raw-encoding signed-magnitude less-than
  function lt_raw;
    input [31:0] x;
    input [31:0] y;
    begin
      if (x[31] != y[31])
        lt_raw = x[31];
      else if (x[31])
        lt_raw = x[30:0] > y[30:0];
      else
        lt_raw = x[30:0] < y[30:0];
    end
  endfunction

  function [31:0] clamp_max;
    input [31:0] v;
    begin
      if (v[30:23] == 8'hFF && v[22:0] != 23'h0)
        clamp_max = `FMM_POS_INF;
      else if (v[30:23] == 8'h00 && v[22:0] != 23'h0)
        clamp_max = `FMM_POS_ZERO;
      else
        clamp_max = v;
    end
  endfunction

  // ****************************************
  // Multiply and add units
  // ****************************************
  wire [31:0] mul_res, add_res;
  wire        mul_uf, mul_of, add_uf, add_of;
  fmm_fp_unit u_mul (
    .op_a   (fr_q[mac_e]),
    .op_b   (fr_q[mac_f]),
    .is_mul (1'b1),
    .res    (mul_res),
    .uflow  (mul_uf),
    .oflow  (mul_of)
  );
  fmm_fp_unit u_add (
    .op_a   (fr_q[7]),
    .op_b   (fr_q[6]),
    .is_mul (1'b0),
    .res    (add_res),
    .uflow  (add_uf),
    .oflow  (add_of)
  );

  // Two-cycle stage: results captured at issue, written a cycle later.
  // Issuer keeps the delay slot off the pending registers.
  reg        pend_q;
  reg [2:0]  pend_dst_q;
  reg [31:0] pend_mul_q, pend_add_q;
  reg        pend_uf_q, pend_of_q;

  // ****************************************
  // Next-state logic
  // ****************************************
  reg [31:0] a_val, b_val, mx;
  reg        lt_ab;
  integer    k;
  integer    j;
  always @* begin
    for (k = 0; k < NREG; k = k + 1)
      fr_d[k] = fr_q[k];
    stat_d = float_status_register_q;
    a_val = fr_q[max_a];
    b_val = is_maxi ? imm_val : fr_q[max_b];
    lt_ab = lt_raw(a_val, b_val);
    mx = clamp_max(lt_ab ? b_val : a_val);
    // Retire the pending multiply-accumulate results
    if (pend_q) begin
      fr_d[pend_dst_q] = pend_mul_q;
      fr_d[7] = pend_add_q;
      if (pend_uf_q)
        stat_d[`FMM_BIT_UNF_LATCH] = 1'b1;
      if (pend_of_q)
        stat_d[`FMM_BIT_OVF_LATCH] = 1'b1;
    end
    if (is_mac) begin
      // Move dest is never 7, 3 or the multiply dest.
      fr_d[mac_a] = mem_rdata;
      stat_d[`FMM_BIT_FNEG] = mem_rdata[31];
      stat_d[`FMM_BIT_FZERO] = 1'b0;
      if (mem_rdata[30:23] == 8'h00) begin
        stat_d[`FMM_BIT_FZERO] = 1'b1;
        stat_d[`FMM_BIT_FNEG] = 1'b0;
      end
      stat_d[`FMM_BIT_INEG] = mem_rdata[31];
      stat_d[`FMM_BIT_IZERO] = (mem_rdata == 32'h00000000);
    end else if (is_maxr || is_maxi) begin
      if (lt_ab)
        fr_d[max_a] = mx;
      else
        fr_d[max_a] = clamp_max(a_val);
      // Only the float zero and negative flags change.
      stat_d[`FMM_BIT_FZERO] = (a_val == b_val);
      stat_d[`FMM_BIT_FNEG] = lt_ab;
    end else if (reg_wr_en) begin
      fr_d[reg_wr_sel] = reg_wr_data;
    end
  end

  // ****************************************
  // State registers
  // ****************************************
  always @(posedge clk_sys) begin
    if (reset) begin
      for (j = 0; j < NREG; j = j + 1)
        fr_q[j] <= 32'h00000000;
      float_status_register_q <= `FMM_STAT_RST;
      pend_q <= 1'b0;
      pend_dst_q <= 3'd0;
      pend_mul_q <= 32'h00000000;
      pend_add_q <= 32'h00000000;
      pend_uf_q <= 1'b0;
      pend_of_q <= 1'b0;
      reg_rd_data_q <= 32'h00000000;
      op_accepted_q <= 1'b0;
      mac_busy_q <= 1'b0;
    end else begin
      for (j = 0; j < NREG; j = j + 1)
        fr_q[j] <= fr_d[j];
      float_status_register_q <= stat_d;
      pend_q <= is_mac;
      pend_dst_q <= mac_d;
      pend_mul_q <= mul_res;
      pend_add_q <= add_res;
      pend_uf_q <= mul_uf | add_uf;
      pend_of_q <= mul_of | add_of;
      reg_rd_data_q <= fr_q[reg_rd_sel];
      op_accepted_q <= is_mac | is_maxr | is_maxi;
      mac_busy_q <= is_mac;
    end
  end
endmodule
`default_nettype wire

// ---- fmm_datapath_assertions.sv ----
// Port-level assertions for the float multiply-accumulate and maximum datapath
`timescale 1ns/1ps
`default_nettype none
`include "fmm_regs.vh"
module fmm_chk (
  input wire logic        clk_sys,
  input wire logic        reset,
  input wire logic        issue_valid,
  input wire logic [15:0] instr_word1,
  input wire logic [15:0] instr_word2,
  input wire logic [31:0] mem_rdata,
  input wire logic [6:0]  float_status_register_q,
  input wire logic        op_accepted_q,
  input wire logic        mac_busy_q
);
  wire logic [6:0] st = float_status_register_q;
  wire logic mac = issue_valid && ((instr_word1 & `FMM_MAC_MASK) == `FMM_MAC_PAT);
  wire logic mxr = (instr_word1 == `FMM_MAXR_PAT) && ((instr_word2 & `FMM_MAXR_W2MASK) == 16'h0000);
  wire logic mx = issue_valid && (mxr || ((instr_word1 & `FMM_MAXI_MASK) == `FMM_MAXI_PAT));
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  a_mac_busy: assert property (mac |=> mac_busy_q)
    else $error("busy flag missing after multiply-accumulate");
  a_busy_pulse: assert property (mac_busy_q && !mac |=> !mac_busy_q)
    else $error("busy flag held too long");
  a_op_accept: assert property ((mac || mx) |=> op_accepted_q)
    else $error("known operation not accepted");
  a_junk_refused: assert property (!(mac || mx) |=> !op_accepted_q)
    else $error("unknown word accepted");
  a_max_keeps: assert property (mx && !mac_busy_q |=> st[6:4] == $past(st[6:4])
    && st[1:0] == $past(st[1:0]))
    else $error("maximum touched other flags");
  a_int_flags: assert property (mac |=> st[4] == $past(mem_rdata[31])
    && st[5] == ($past(mem_rdata) == 32'h00000000))
    else $error("integer flags wrong after move");
  a_float_flags: assert property (mac |=> st[3:2] == (($past(mem_rdata[30:23]) == 8'h00)
    ? 2'b10 : {1'b0, $past(mem_rdata[31])}))
    else $error("float flags wrong after move");
  a_under_cause: assert property ($rose(st[1]) |-> $past(mac_busy_q))
    else $error("underflow latched without pending multiply-accumulate");
  a_over_cause: assert property ($rose(st[0]) |-> $past(mac_busy_q))
    else $error("overflow latched without pending multiply-accumulate");
  a_test_hold: assert property (!st[6])
    else $error("test flag changed");
  cover property (mac ##1 mac_busy_q);
  cover property ($rose(st[0]) && $rose(st[1]));
  cover property (mx ##1 st[2]);
endmodule
bind fmm_datapath fmm_chk i_chk (.clk_sys(clk_sys), .reset(reset), .issue_valid(issue_valid),
  .instr_word1(instr_word1), .instr_word2(instr_word2), .mem_rdata(mem_rdata),
  .float_status_register_q(float_status_register_q), .op_accepted_q(op_accepted_q),
  .mac_busy_q(mac_busy_q));
`default_nettype wire

// ---- fmm_cpu_model.sv ----
// Issue stage and memory read path feeding the datapath
`timescale 1ns/1ps
`default_nettype none
module fmm_cpu_model (
  input  wire logic        clk_sys,
  output var  logic        issue_valid,
  output var  logic [15:0] instr_word1,
  output var  logic [15:0] instr_word2,
  output var  logic [31:0] mem_rdata
);
  initial begin
    issue_valid = 1'b0;
    instr_word1 = 16'h0000;
    instr_word2 = 16'h0000;
    mem_rdata = 32'h00000000;
  end
  // Operands scrambled after the issue cycle so late sampling shows up
  // Callers keep the move target off reg 7, reg 3 and the product target
  // Every issue is followed by an idle slot, so pending results are never touched
  task automatic issue(input logic [15:0] w1, input logic [15:0] w2, input logic [31:0] m);
    @(posedge clk_sys);
    issue_valid <= 1'b1;
    instr_word1 <= w1;
    instr_word2 <= w2;
    mem_rdata <= m;
    @(posedge clk_sys);
    issue_valid <= 1'b0;
    instr_word1 <= ~w1;
    instr_word2 <= ~w2;
    mem_rdata <= ~m;
  endtask
endmodule
`default_nettype wire

// ---- tb.sv ----
// Self-checking bench for the float datapath
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        clk_sys;
  logic        reset;
  logic        reg_wr_en;
  logic [2:0]  reg_wr_sel;
  logic [31:0] reg_wr_data;
  logic [2:0]  reg_rd_sel;
  wire         issue_valid;
  wire [15:0]  instr_word1;
  wire [15:0]  instr_word2;
  wire [31:0]  mem_rdata;
  wire [31:0]  reg_rd_data_q;
  wire [6:0]   float_status_register_q;
  wire         op_accepted_q;
  wire         mac_busy_q;
  int          mismatches;
  int          checked;
`define FMM_EQ(a, e) begin checked++; if ((a) !== (e)) begin mismatches++; \
  $display("ERROR t=%0t got %h exp %h", $time, a, e); end end
  fmm_cpu_model i_cpu (.clk_sys(clk_sys), .issue_valid(issue_valid), .instr_word1(instr_word1),
    .instr_word2(instr_word2), .mem_rdata(mem_rdata));
  fmm_datapath i_dut (.clk_sys(clk_sys), .reset(reset), .issue_valid(issue_valid),
    .instr_word1(instr_word1), .instr_word2(instr_word2), .mem_rdata(mem_rdata),
    .reg_wr_en(reg_wr_en), .reg_wr_sel(reg_wr_sel), .reg_wr_data(reg_wr_data),
    .reg_rd_sel(reg_rd_sel), .reg_rd_data_q(reg_rd_data_q),
    .float_status_register_q(float_status_register_q), .op_accepted_q(op_accepted_q),
    .mac_busy_q(mac_busy_q));
  always #2.5 clk_sys = ~clk_sys;
  task automatic wrap_up;
    if (mismatches == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [2:0] s, input logic [31:0] d);
    @(posedge clk_sys);
    reg_wr_en <= 1'b1;
    reg_wr_sel <= s;
    reg_wr_data <= d;
    @(posedge clk_sys);
    reg_wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] s, input logic [31:0] e);
    @(posedge clk_sys);
    reg_rd_sel <= s;
    @(posedge clk_sys);
    #1 `FMM_EQ(reg_rd_data_q, e)
  endtask
  // Status sampled two edges on, so both one- and two-cycle results have landed
  task automatic op(input logic [15:0] w1, input logic [15:0] w2, input logic [31:0] m,
                    input logic acc, input logic [6:0] s);
    i_cpu.issue(w1, w2, m);
    #1 `FMM_EQ(op_accepted_q, acc)
    @(posedge clk_sys);
    #1 `FMM_EQ(float_status_register_q, s)
  endtask
  initial begin
    repeat (4000) @(posedge clk_sys);
    mismatches++;
    wrap_up();
  end
  initial begin
    clk_sys = 1'b0;
    reset = 1'b1;
    reg_wr_en = 1'b0;
    reg_wr_sel = 3'h0;
    reg_wr_data = 32'h00000000;
    reg_rd_sel = 3'h0;
    mismatches = 0;
    checked = 0;
    repeat (3) @(posedge clk_sys);
    reset <= 1'b0;
    #1 `FMM_EQ(float_status_register_q, 7'h00)
    wr(3'h0, 32'h40A00000);
    wr(3'h1, 32'h40800000);
    wr(3'h2, 32'hBFC00000);
    wr(3'h3, 32'hC0000000);
    wr(3'h6, 32'h3F800000);
    wr(3'h7, 32'h40000000);
    op(16'hE696, 16'h0001, 32'h0, 1'b1, 7'h04);
    rd(3'h1, 32'h40A00000);
    op(16'hE696, 16'h0008, 32'h0, 1'b1, 7'h08);
    op(16'hE696, 16'h001A, 32'h0, 1'b1, 7'h00);
    rd(3'h2, 32'hBFC00000);
    op(16'hE697, 16'h0001, 32'h0, 1'b0, 7'h00);
    op(16'hE696, 16'h0041, 32'h0, 1'b0, 7'h00);
    op(16'hE825, 16'hFC02, 32'h0, 1'b1, 7'h04);
    rd(3'h2, 32'hBF800000);
    op(16'hE823, 16'hFE04, 32'h0, 1'b1, 7'h04);
    rd(3'h4, 32'h7F800000);
    op(16'hE820, 16'h0205, 32'h0, 1'b1, 7'h04);
    rd(3'h5, 32'h00000000);
    op(16'hE3C2, 16'h2A00, 32'h80000000, 1'b1, 7'h18);
    rd(3'h2, 32'h80000000);
    rd(3'h5, 32'h41C80000);
    rd(3'h7, 32'h40400000);
    wr(3'h3, 32'h00800000);
    wr(3'h6, 32'h7F000000);
    wr(3'h7, 32'h7F000000);
    op(16'hE3C6, 16'hC100, 32'h00000001, 1'b1, 7'h0B);
    rd(3'h1, 32'h00000001);
    op(16'hE696, 16'h000A, 32'h0, 1'b1, 7'h07);
    rd(3'h2, 32'h00000000);
    wrap_up();
  end
endmodule
`default_nettype wire
